/* bench/fifo_partner.sv */
// writer and reader logic on the data side of the fifo
`timescale 1ns/1ps
`include "fifo_map.svh"

module fifo_partner
(
  input  wire logic                    aclk,
  output logic                         write_clk_en,
  output logic                         write_enable_n,
  output logic [`FIFO_DATA_W-1:0]      data_in_bus,
  output logic                         read_clk_en,
  output logic                         read_enable_n,
  output logic                         retransmit_n
);
  initial
  begin
    write_clk_en   = 1'b0;
    write_enable_n = 1'b1;
    data_in_bus    = '0;
    read_clk_en    = 1'b0;
    read_enable_n  = 1'b1;
    retransmit_n   = 1'b1;
  end

  // one write edge, then an idle gap of the caller's choosing
  task automatic wr(input logic [`FIFO_DATA_W-1:0] d, input int gap);
    @(posedge aclk);
    write_clk_en   <= 1'b1;
    write_enable_n <= 1'b0;
    data_in_bus    <= d;
    @(posedge aclk);
    write_clk_en   <= 1'b0;
    write_enable_n <= 1'b1;
    data_in_bus    <= ~d;
    repeat (gap) @(posedge aclk);
  endtask

  // one read edge with chosen enable and retransmit levels
  task automatic rd(input logic en_n, input logic rt_n, input int gap);
    @(posedge aclk);
    read_clk_en   <= 1'b1;
    read_enable_n <= en_n;
    retransmit_n  <= rt_n;
    @(posedge aclk);
    read_clk_en   <= 1'b0;
    read_enable_n <= 1'b1;
    retransmit_n  <= 1'b1;
    repeat (gap) @(posedge aclk);
  endtask
endmodule // fifo_partner

/* bench/tb_dual_clock_fifo_with_flags.sv */
// self-checking bench for the flagged fifo
`timescale 1ns/1ps
`include "fifo_map.svh"

`define CHK(a, e) \
  begin \
    checks_done++; \
    if ((a) !== (e)) \
    begin \
      failures++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); \
    end \
  end

module tb_dual_clock_fifo_with_flags;
  logic                    aclk, aresetn, awvalid, wvalid, bready;
  logic                    arvalid, rready, awready, wready, bvalid;
  logic                    arready, rvalid;
  logic [7:0]              awaddr, araddr;
  logic [31:0]             wdata, rdata, rd_val;
  logic [3:0]              wstrb;
  logic [1:0]              bresp, rresp, rsp;
  logic                    wce, rce, wen_n, ren_n, oe_n, mrs_n, prs_n;
  logic                    rt_n, msel, ld_n, oe, ef_n, ff_n, hf_n;
  logic                    ae_n, af_n, sen_n;
  logic [`FIFO_DATA_W-1:0] din, dout;
  int                      failures, checks_done;

  fifo_partner i_fifo_partner (.aclk(aclk), .write_clk_en(wce),
    .write_enable_n(wen_n), .data_in_bus(din), .read_clk_en(rce),
    .read_enable_n(ren_n), .retransmit_n(rt_n));

  dual_clock_fifo_with_flags i_dual_clock_fifo_with_flags (.aclk(aclk),
    .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .write_clk_en(wce),
    .read_clk_en(rce), .write_enable_n(wen_n), .read_enable_n(ren_n),
    .data_in_bus(din), .output_enable_n(oe_n), .master_reset_n(mrs_n),
    .partial_reset_n(prs_n), .retransmit_n(rt_n),
    .mode_select_serial_in(msel), .serial_load_enable_n(sen_n),
    .offset_access_select_n(ld_n), .data_out_bus(dout),
    .data_out_oe(oe), .empty_flag_n(ef_n), .full_flag_n(ff_n),
    .half_full_flag_n(hf_n), .almost_empty_flag_n(ae_n),
    .almost_full_flag_n(af_n));

  always #4 aclk = ~aclk;

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_done, w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (awready && awvalid)
      begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && wvalid)
      begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    @(posedge aclk);
    while (!arready) @(posedge aclk);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rd_val = rdata;
    rsp    = rresp;
    rready <= 1'b0;
  endtask

  // master reset with mode strap and offset select strap
  task automatic mrst(input logic m, input logic s);
    mrs_n <= 1'b0;
    msel  <= m;
    ld_n  <= s;
    settle(2);
    mrs_n <= 1'b1;
    settle(1);
    msel  <= 1'b0;
    ld_n  <= 1'b1;
    settle(2);
  endtask

  task automatic rd_chk(input logic en_n, input logic [8:0] e);
    i_fifo_partner.rd(en_n, 1'b1, 0);
    settle(2);
    `CHK(dout, e)
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    failures++;
    results();
  end

  initial
  begin
    {aclk, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {oe_n, msel, aresetn} = '0;
    {mrs_n, prs_n, ld_n, sen_n} = 4'hf;
    settle(3);
    aresetn <= 1'b1;
    axi_wr(`FIFO_CTRL_ADDR, 32'h0);
    `CHK(rsp, `FIFO_RESP_OKAY)
    axi_wr(8'h0c, 32'h1);
    `CHK(rsp, `FIFO_RESP_SLVERR)
    axi_rd(8'h0c);
    `CHK(rsp, `FIFO_RESP_SLVERR)
    `CHK(rd_val, 32'h0)
    mrst(1'b0, 1'b0);
    axi_rd(`FIFO_STATUS_ADDR);
    `CHK(rd_val, 32'h16)
    axi_rd(`FIFO_CTRL_ADDR);
    `CHK(rd_val, 32'h0)
    $display("test bus and reset done");
    rd_chk(1'b0, 9'h000);
    i_fifo_partner.wr(9'h1a5, 3);
    i_fifo_partner.wr(9'h05a, 0);
    settle(3);
    `CHK(ef_n, 1'b1)
    `CHK(dout, 9'h000)
    rd_chk(1'b0, 9'h1a5);
    rd_chk(1'b0, 9'h05a);
    i_fifo_partner.rd(1'b1, 1'b0, 0);
    rd_chk(1'b0, 9'h1a5);
    axi_rd(`FIFO_COUNT_ADDR);
    `CHK(rd_val, 32'h1)
    oe_n <= 1'b1;
    settle(1);
    `CHK(oe, 1'b0)
    oe_n <= 1'b0;
    settle(1);
    `CHK(oe, 1'b1)
    $display("test standard mode done");
    mrst(1'b0, 1'b0);
    ld_n <= 1'b0;
    // empty offset 5, full offset 7, low word first
    for (int k = 0; k < 4; k++)
      i_fifo_partner.wr(k[0] ? 9'h000 : 9'(k + 5), 0);
    ld_n <= 1'b1;
    prs_n <= 1'b0;
    settle(2);
    prs_n <= 1'b1;
    settle(3);
    axi_rd(`FIFO_COUNT_ADDR);
    `CHK(rd_val, 32'h0)
    ld_n <= 1'b0;
    rd_chk(1'b0, 9'h005);
    rd_chk(1'b0, 9'h000);
    rd_chk(1'b0, 9'h007);
    rd_chk(1'b0, 9'h000);
    ld_n <= 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      settle(3);
      `CHK(ae_n, 1'b0)
      i_fifo_partner.wr(9'(k), 0);
    end
    settle(3);
    `CHK(ae_n, 1'b1)
    $display("test offsets done");
    mrst(1'b1, 1'b1);
    axi_rd(`FIFO_STATUS_ADDR);
    `CHK(rd_val, 32'h75)
    ld_n <= 1'b0;
    rd_chk(1'b0, 9'h1ff);
    rd_chk(1'b0, 9'h001);
    ld_n <= 1'b1;
    i_fifo_partner.wr(9'h0c3, 0);
    repeat (3) i_fifo_partner.rd(1'b1, 1'b1, 0);
    settle(2);
    `CHK(dout, 9'h0c3)
    `CHK(ef_n, 1'b0)
    i_fifo_partner.wr(9'h13c, 0);
    settle(3);
    `CHK(dout, 9'h0c3)
    rd_chk(1'b0, 9'h13c);
    $display("test fall-through done");
    // serial load: both offsets become 2, lsb first, empty then full
    ld_n  <= 1'b0;
    sen_n <= 1'b0;
    for (int k = 0; k < 34; k++)
    begin
      msel <= (k == 1 || k == 18);
      i_fifo_partner.wr(9'h000, 0);
    end
    sen_n <= 1'b1;
    msel  <= 1'b0;
    rd_chk(1'b0, 9'h002);
    rd_chk(1'b0, 9'h000);
    rd_chk(1'b0, 9'h002);
    rd_chk(1'b0, 9'h000);
    ld_n  <= 1'b1;
    $display("test serial offsets done");
    results();
  end
endmodule // tb_dual_clock_fifo_with_flags

/* hdl/dual_clock_fifo_with_flags.sv */
// flagged 9-bit fifo with offset registers and an axi4-lite status port
`timescale 1ns/1ps
`include "fifo_map.svh"

// What this block does
// - store 9-bit words, 65536 or 131072 deep by organization
// - write edge with write enable low stores the input word
// - read edge with read enable low advances to the next word
// - write and read edges are independent, no rate relation
// - output enable low drives the data bus, high releases it
// - standard mode: new word stays off the output until read
// - standard mode: read edge moves word from memory to output
// - fall-through mode: first word appears after three read edges
// - fall-through mode: later words need read enable low
// - mode pin level during master reset picks the timing mode
// - shared flags are empty/full or ready flags; others always work
// - separate empty and full offset registers, any value
// - default offsets place flags 127 or 1023 from the boundaries
// - serial: write edge with serial enable and select shifts one bit
// - parallel: write edge with enable and select loads from data in
// - read edge with enable and select puts offsets on the output
// - master reset zeroes both pointers
// - select level at master reset: 127 parallel or 1023 serial
// - after master reset flags follow chosen mode and offsets
// - partial reset zeroes both pointers
// - partial reset keeps mode, method and offsets
// - retransmit low at read edge zeroes the read pointer
// - almost-full low when count exceeds capacity minus full offset
// - almost-empty low when count is below the empty offset
// - retransmit briefly shows empty, leaves other settings alone
module dual_clock_fifo_with_flags
  import fifo_pkg::*;
(
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [`FIFO_ADDR_W-1:0]   awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  input  wire logic [`FIFO_ADDR_W-1:0]   araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  input  wire logic                      write_clk_en,
  input  wire logic                      read_clk_en,
  input  wire logic                      write_enable_n,
  input  wire logic                      read_enable_n,
  input  wire logic [`FIFO_DATA_W-1:0]   data_in_bus,
  input  wire logic                      output_enable_n,
  input  wire logic                      master_reset_n,
  input  wire logic                      partial_reset_n,
  input  wire logic                      retransmit_n,
  input  wire logic                      mode_select_serial_in,
  input  wire logic                      serial_load_enable_n,
  input  wire logic                      offset_access_select_n,
  output logic [`FIFO_DATA_W-1:0]        data_out_bus,
  output logic                           data_out_oe,
  output logic                           empty_flag_n,
  output logic                           full_flag_n,
  output logic                           half_full_flag_n,
  output logic                           almost_empty_flag_n,
  output logic                           almost_full_flag_n
);
  import fifo_pkg::*;

  logic [`FIFO_DATA_W-1:0] mem [0:`FIFO_DEPTH_LARGE-1];

  mode_t                   mode_reg;
  load_method_t            method_reg;
  logic                    org_sel_reg;
  logic                    org_large_reg;
  logic [`FIFO_PTR_W-1:0]  wptr_reg;
  logic [`FIFO_PTR_W-1:0]  wptr_next;
  logic [`FIFO_PTR_W-1:0]  rptr_reg;
  logic                    wrapped_reg;
  logic                    wrapped_next;
  logic [`FIFO_CNT_W-1:0]  mem_count_reg;
  logic [`FIFO_CNT_W-1:0]  total;
  logic [`FIFO_CNT_W-1:0]  depth;
  logic                    out_valid_reg;
  logic [1:0]              lat_reg;
  logic                    rt_hold_reg;
  logic [`FIFO_OFS_W-1:0]  empty_ofs_reg;
  logic [`FIFO_OFS_W-1:0]  full_ofs_reg;
  logic [1:0]              par_idx_reg;
  logic [1:0]              rd_idx_reg;
  logic [5:0]              ser_idx_reg;
  logic [`FIFO_DATA_W-1:0] q_reg;
  logic [`FIFO_DATA_W-1:0] ofs_word;
  logic                    in_reset;
  logic                    full_int;
  logic                    push;
  logic                    pop;
  logic                    rt_edge;
  logic                    ofs_read;
  logic                    ofs_par_wr;
  logic                    ofs_ser_wr;

  // pointer and count control
  assign in_reset  = !master_reset_n || !partial_reset_n;
  assign depth     = org_large_reg ? `FIFO_DEPTH_LARGE : `FIFO_DEPTH_SMALL;
  assign total     = mem_count_reg
                   + {{(`FIFO_CNT_W-1){1'b0}},
                      (mode_reg == MODE_FIRST_WORD_FALLTHROUGH_MODE) && out_valid_reg};
  assign full_int  = total >= depth;
  assign rt_edge   = read_clk_en && !retransmit_n && !in_reset;
  assign push      = write_clk_en && !write_enable_n
                   && offset_access_select_n && !full_int
                   && !in_reset;
  always_comb
  begin
    pop = 1'b0;
    if (read_clk_en && !in_reset && !rt_edge && offset_access_select_n
        && mem_count_reg != '0)
    begin
      if (mode_reg == MODE_STANDARD)
        pop = !read_enable_n;
      else if (!out_valid_reg)
        pop = lat_reg == `FIFO_FIRST_WORD_FALLTHROUGH_MODE_LAST;
      else
        pop = !read_enable_n;
    end
  end

  always_comb
  begin
    wptr_next    = wptr_reg;
    wrapped_next = wrapped_reg;
    if (push)
    begin
      if ({1'b0, wptr_reg} == depth - 18'h00001)
      begin
        wptr_next    = '0;
        wrapped_next = 1'b1;
      end
      else
        wptr_next = wptr_reg + 17'h00001;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (push)
      mem[wptr_reg] <= data_in_bus;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || in_reset)
    begin
      wptr_reg    <= '0;
      wrapped_reg <= 1'b0;
    end
    else
    begin
      wptr_reg    <= wptr_next;
      wrapped_reg <= wrapped_next;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || in_reset)
      rptr_reg <= '0;
    else if (rt_edge)
      rptr_reg <= '0;
    else if (pop)
    begin
      if ({1'b0, rptr_reg} == depth - 18'h00001)
        rptr_reg <= '0;
      else
        rptr_reg <= rptr_reg + 17'h00001;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || in_reset)
      mem_count_reg <= '0;
    else if (rt_edge)
      mem_count_reg <= wrapped_next ? depth : {1'b0, wptr_next};
    else if (push && !pop)
      mem_count_reg <= mem_count_reg + 18'h00001;
    else if (pop && !push)
      mem_count_reg <= mem_count_reg - 18'h00001;
  end

  // fall-through output stage and retransmit hold
  always_ff @(posedge aclk)
  begin
    if (!aresetn || in_reset || rt_edge)
    begin
      out_valid_reg <= 1'b0;
      lat_reg       <= '0;
    end
    else if (read_clk_en && mode_reg == MODE_FIRST_WORD_FALLTHROUGH_MODE)
    begin
      if (pop)
        out_valid_reg <= 1'b1;
      else if (out_valid_reg && !read_enable_n && offset_access_select_n)
        out_valid_reg <= 1'b0;
      if (out_valid_reg || mem_count_reg == '0)
        lat_reg <= '0;
      else if (lat_reg != `FIFO_FIRST_WORD_FALLTHROUGH_MODE_LAST)
        lat_reg <= lat_reg + 2'h1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || in_reset)
      rt_hold_reg <= 1'b0;
    else
      rt_hold_reg <= rt_edge;
  end

  // configuration captured while master reset is low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_reg      <= MODE_STANDARD;
      method_reg    <= LOAD_PARALLEL;
      org_large_reg <= `FIFO_CTRL_RESET;
    end
    else if (!master_reset_n)
    begin
      mode_reg      <= mode_select_serial_in ? MODE_FIRST_WORD_FALLTHROUGH_MODE
                                             : MODE_STANDARD;
      method_reg    <= offset_access_select_n ? LOAD_SERIAL
                                              : LOAD_PARALLEL;
      org_large_reg <= org_sel_reg;
    end
  end

  // offset registers
  assign ofs_par_wr = write_clk_en && !in_reset && !write_enable_n
                    && !offset_access_select_n
                    && method_reg == LOAD_PARALLEL;
  assign ofs_ser_wr = write_clk_en && !in_reset && !serial_load_enable_n
                    && !offset_access_select_n
                    && method_reg == LOAD_SERIAL;
  assign ofs_read   = read_clk_en && !in_reset && !read_enable_n
                    && !offset_access_select_n;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      empty_ofs_reg <= `FIFO_OFS_DEF_PAR;
      full_ofs_reg  <= `FIFO_OFS_DEF_PAR;
    end
    else if (!master_reset_n)
    begin
      empty_ofs_reg <= offset_access_select_n ? `FIFO_OFS_DEF_SER
                                              : `FIFO_OFS_DEF_PAR;
      full_ofs_reg  <= offset_access_select_n ? `FIFO_OFS_DEF_SER
                                              : `FIFO_OFS_DEF_PAR;
    end
    else if (!partial_reset_n)
    begin
      empty_ofs_reg <= empty_ofs_reg;
      full_ofs_reg  <= full_ofs_reg;
    end
    else if (ofs_par_wr)
    begin
      unique case (par_idx_reg)
        2'h0: empty_ofs_reg[`FIFO_LOW_W-1:0] <= data_in_bus;
        2'h1: empty_ofs_reg[`FIFO_OFS_W-1:`FIFO_LOW_W] <=
                data_in_bus[`FIFO_HIGH_W-1:0];
        2'h2: full_ofs_reg[`FIFO_LOW_W-1:0] <= data_in_bus;
        2'h3: full_ofs_reg[`FIFO_OFS_W-1:`FIFO_LOW_W] <=
                data_in_bus[`FIFO_HIGH_W-1:0];
      endcase
    end
    else if (ofs_ser_wr)
    begin
      if (ser_idx_reg < `FIFO_SER_SPLIT)
        empty_ofs_reg[ser_idx_reg[4:0]] <= mode_select_serial_in;
      else
        full_ofs_reg[5'(ser_idx_reg - `FIFO_SER_SPLIT)] <=
          mode_select_serial_in;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || in_reset)
    begin
      par_idx_reg <= '0;
      ser_idx_reg <= '0;
    end
    else
    begin
      if (ofs_par_wr)
        par_idx_reg <= par_idx_reg + 2'h1;
      if (ofs_ser_wr)
        ser_idx_reg <= (ser_idx_reg == `FIFO_SER_LAST) ? 6'h00
                     : ser_idx_reg + 6'h01;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || in_reset)
      rd_idx_reg <= '0;
    else if (ofs_read)
      rd_idx_reg <= rd_idx_reg + 2'h1;
  end

  always_comb
  begin
    unique case (rd_idx_reg)
      2'h0: ofs_word = empty_ofs_reg[`FIFO_LOW_W-1:0];
      2'h1: ofs_word = {1'b0, empty_ofs_reg[`FIFO_OFS_W-1:`FIFO_LOW_W]};
      2'h2: ofs_word = full_ofs_reg[`FIFO_LOW_W-1:0];
      2'h3: ofs_word = {1'b0, full_ofs_reg[`FIFO_OFS_W-1:`FIFO_LOW_W]};
    endcase
  end

  // output register and drive
  always_ff @(posedge aclk)
  begin
    if (!aresetn || in_reset)
      q_reg <= '0;
    else if (ofs_read)
      q_reg <= ofs_word;
    else if (pop)
      q_reg <= mem[rptr_reg];
  end

  assign data_out_bus = q_reg;
  assign data_out_oe  = !output_enable_n;

  // flags, registered one cycle after the count
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      empty_flag_n        <= 1'b0;
      full_flag_n         <= 1'b1;
      half_full_flag_n    <= 1'b1;
      almost_empty_flag_n <= 1'b0;
      almost_full_flag_n  <= 1'b1;
    end
    else
    begin
      if (mode_reg == MODE_STANDARD)
      begin
        empty_flag_n <= mem_count_reg != '0 && !rt_hold_reg && !rt_edge;
        full_flag_n  <= !full_int;
      end
      else
      begin
        empty_flag_n <= !out_valid_reg || rt_edge;
        full_flag_n  <= full_int;
      end
      half_full_flag_n    <= !(total > (depth >> 1));
      almost_empty_flag_n <= !(total < {1'b0, empty_ofs_reg});
      almost_full_flag_n  <=
        !(total > depth - {1'b0, full_ofs_reg});
    end
  end

  // axi4-lite slave
  logic                    aw_got_reg;
  logic                    w_got_reg;
  logic [`FIFO_ADDR_W-1:0] aw_addr_reg;
  logic [31:0]             w_data_reg;
  logic [3:0]              w_strb_reg;

  assign awready = !aw_got_reg;
  assign wready  = !w_got_reg;
  assign arready = !rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bvalid      <= 1'b0;
      bresp       <= `FIFO_RESP_OKAY;
      org_sel_reg <= `FIFO_CTRL_RESET;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_got_reg  <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (aw_got_reg && w_got_reg && !bvalid)
      begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid     <= 1'b1;
        if (aw_addr_reg == `FIFO_CTRL_ADDR)
        begin
          bresp <= `FIFO_RESP_OKAY;
          if (w_strb_reg[0])
            org_sel_reg <= w_data_reg[`FIFO_CTRL_ORG_BIT];
        end
        else if (aw_addr_reg == `FIFO_STATUS_ADDR
                 || aw_addr_reg == `FIFO_COUNT_ADDR)
          bresp <= `FIFO_RESP_OKAY;
        else
          bresp <= `FIFO_RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= `FIFO_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rresp  <= `FIFO_RESP_OKAY;
      unique case (araddr)
        `FIFO_CTRL_ADDR:
          rdata <= {30'h0, org_large_reg, org_sel_reg};
        `FIFO_STATUS_ADDR:
          rdata <= {25'h0, method_reg == LOAD_SERIAL,
                    mode_reg == MODE_FIRST_WORD_FALLTHROUGH_MODE, almost_full_flag_n,
                    almost_empty_flag_n, half_full_flag_n,
                    full_flag_n, empty_flag_n};
        `FIFO_COUNT_ADDR:
          rdata <= {14'h0, total};
        default:
        begin
          rdata <= '0;
          rresp <= `FIFO_RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

  // checks
  property p_mrs_ptrs;
    @(posedge aclk) disable iff (!aresetn)
    !master_reset_n |=> wptr_reg == '0 && rptr_reg == '0;
  endproperty
  a_mrs_ptrs: assert property (p_mrs_ptrs)
    else $error("pointers not cleared by master reset");

  property p_prs_keep;
    @(posedge aclk) disable iff (!aresetn)
    master_reset_n && !partial_reset_n |=> rptr_reg == '0
      && $stable(mode_reg) && $stable(empty_ofs_reg)
      && $stable(full_ofs_reg);
  endproperty
  a_prs_keep: assert property (p_prs_keep)
    else $error("partial reset changed settings or kept pointer");

  property p_default_par;
    @(posedge aclk) disable iff (!aresetn)
    !master_reset_n && !offset_access_select_n |=>
      empty_ofs_reg == 17'h0007f && full_ofs_reg == 17'h0007f
      && method_reg == LOAD_PARALLEL;
  endproperty
  a_default_par: assert property (p_default_par)
    else $error("wrong default offset for parallel method");

  property p_full_write;
    @(posedge aclk) disable iff (!aresetn)
    full_int && write_clk_en && !write_enable_n && !in_reset
      |=> $stable(wptr_reg);
  endproperty
  a_full_write: assert property (p_full_write)
    else $error("write pointer moved while full");

  property p_write_step;
    @(posedge aclk) disable iff (!aresetn)
    push && {1'b0, wptr_reg} < depth - 18'h00001
      |=> wptr_reg == $past(wptr_reg) + 17'h00001;
  endproperty
  a_write_step: assert property (p_write_step)
    else $error("accepted write did not advance pointer");

  property p_retransmit;
    @(posedge aclk) disable iff (!aresetn)
    rt_edge && mode_reg == MODE_STANDARD
      |=> rptr_reg == '0 ##0 !empty_flag_n ##1 !empty_flag_n;
  endproperty
  a_retransmit: assert property (p_retransmit)
    else $error("retransmit did not rewind and flag empty");

  property p_first_word_fallthrough_mode_first;
    @(posedge aclk) disable iff (!aresetn)
    mode_reg == MODE_FIRST_WORD_FALLTHROUGH_MODE && pop && !out_valid_reg
      |=> out_valid_reg ##1 !empty_flag_n;
  endproperty
  a_first_word_fallthrough_mode_first: assert property (p_first_word_fallthrough_mode_first)
    else $error("first word did not fall through");

  property p_std_hold;
    @(posedge aclk) disable iff (!aresetn)
    mode_reg == MODE_STANDARD && !pop && !ofs_read && !in_reset
      |=> $stable(q_reg);
  endproperty
  a_std_hold: assert property (p_std_hold)
    else $error("output changed without a read");

  property p_almost_empty;
    @(posedge aclk) disable iff (!aresetn)
    total == '0 && empty_ofs_reg != '0 |=> !almost_empty_flag_n;
  endproperty
  a_almost_empty: assert property (p_almost_empty)
    else $error("almost-empty high with no words");

  property p_oe;
    @(posedge aclk) disable iff (!aresetn)
    output_enable_n |-> !data_out_oe;
  endproperty
  a_oe: assert property (p_oe)
    else $error("data bus driven while output disabled");

endmodule // dual_clock_fifo_with_flags

/* shared/fifo_map.svh */
// constants of the flagged fifo: widths, depths, offsets, register map
`ifndef FIFO_MAP_SVH
`define FIFO_MAP_SVH

`define FIFO_DATA_W       9
`define FIFO_PTR_W        17
`define FIFO_CNT_W        18
`define FIFO_OFS_W        17
`define FIFO_DEPTH_SMALL  18'h10000
`define FIFO_DEPTH_LARGE  18'h20000
`define FIFO_OFS_DEF_PAR  17'h0007f
`define FIFO_OFS_DEF_SER  17'h003ff
`define FIFO_FIRST_WORD_FALLTHROUGH_MODE_LAST    2'h2
`define FIFO_SER_LAST     6'h21
`define FIFO_SER_SPLIT    6'h11
`define FIFO_LOW_W        9
`define FIFO_HIGH_W       8

`define FIFO_ADDR_W       8
`define FIFO_CTRL_ADDR    8'h00
`define FIFO_STATUS_ADDR  8'h04
`define FIFO_COUNT_ADDR   8'h08
`define FIFO_CTRL_ORG_BIT 0
`define FIFO_CTRL_RESET   1'h1
`define FIFO_RESP_OKAY    2'h0
`define FIFO_RESP_SLVERR  2'h2

`endif

/* shared/fifo_pkg.sv */
// types shared by the flagged fifo
package fifo_pkg;
  typedef enum logic {MODE_STANDARD, MODE_FIRST_WORD_FALLTHROUGH_MODE} mode_t;
  typedef enum logic {LOAD_PARALLEL, LOAD_SERIAL} load_method_t;
endpackage
